// *** logic/drive_fault_restart_manager.sv ***
/*
  Fault latch, class sorting, timed auto restart and manual clears.
  Assumes all inputs synchronous to clk; fault_code and fault_class are
  steady while fault_detect is high; command and key inputs are pulses.
*/
// Overview of operation
// - Any detected fault stops motor output and holds it stopped while latched.
// - Each fault is class 1 auto-resettable or class 2 non-resettable, handled accordingly.
// - Class 1 fault with attempt limit above zero loads and starts the restart delay.
// - Delay reaching zero makes one automatic reset attempt.
// - Attempt clears and restarts only if the cause is gone; else stays latched.
// - Class 2 never auto-resets; clears refused while the cause remains active.
// - Escape acknowledges: message removed, keypad returned, fault kept, code recorded.
// - Stop key clears only with stop behaviour 0 to 3; power cycle always clears.
// - Writing 1 or 2 to the fault clear command clears a correctable fault.
// - Toggling an input set to function 10 clears a correctable fault.
// - Nonzero limit with zero delay clears voltage and heatsink faults without restart.
`timescale 1ns/1ps
`default_nettype none
module drive_fault_restart_manager
  import fault_mgr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       fault_detect,
  input  wire logic [7:0] fault_code,
  input  wire logic       fault_class2,
  input  wire logic [3:0] restart_attempt_limit,
  input  wire logic [7:0] restart_delay_setting,
  input  wire logic       fault_clear_write,
  input  wire logic [1:0] fault_clear_command,
  input  wire logic [3:0] stop_behaviour_select,
  input  wire logic       stop_key,
  input  wire logic       escape_key,
  input  wire logic [4:0] input_terminal_function,
  input  wire logic       input_terminal_level,
  output var  logic       motor_enable_reg,
  output var  logic       auto_start_reg,
  output var  logic       fault_latched_reg,
  output var  logic       keypad_owned_reg,
  output var  logic [7:0] latest_fault_code_reg,
  output var  display_t   display_reg
);
  fault_state_t        state_reg;
  logic [7:0]          code_reg;
  logic                class2_reg;
  logic [3:0]          tries_reg;
  logic [7:0]          delay_reg;
  logic [TICK_W-1:0]   tick_reg;
  logic [FLASH_W-1:0]  flash_cnt_reg;
  logic                flash_reg;
  logic                term_prev_reg;
  logic                cause_present;
  logic                manual_clear;
  logic                correctable;
  logic                quiet_fault;

  // Cause still active: same fault still reported
  assign cause_present = fault_detect && (fault_code == code_reg);
  assign correctable   = !cause_present;
  assign manual_clear  = (stop_key && stop_behaviour_select <= STOP_CLEAR_MAX)
                      || (fault_clear_write && (fault_clear_command == CLEAR_CMD_A
                          || fault_clear_command == CLEAR_CMD_B))
                      || (input_terminal_function == TERM_FN_CLEAR
                          && input_terminal_level != term_prev_reg);
  assign quiet_fault   = (code_reg == FAULT_UNDERVOLT) || (code_reg == FAULT_OVERVOLT)
                      || (code_reg == FAULT_HEATSINK);

  // Follows the pin through reset too, so release gives no false toggle
  always_ff @(posedge clk) begin
    term_prev_reg <= input_terminal_level;
  end

  // Fault sequencer; power cycle (reset) always clears
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg    <= ST_RUN;
      code_reg     <= FAULT_NONE;
      class2_reg   <= 1'b0;
      tries_reg    <= 4'h0;
      delay_reg    <= 8'h00;
      tick_reg     <= '0;
      auto_start_reg <= 1'b0;
    end else begin
      auto_start_reg <= 1'b0;
      case (state_reg)
        ST_RUN: begin
          if (fault_detect) begin
            code_reg   <= fault_code;
            class2_reg <= fault_class2;
            tries_reg  <= 4'h0;
            tick_reg   <= '0;
            delay_reg  <= restart_delay_setting;
            if (!fault_class2 && restart_attempt_limit != 4'h0) begin
              state_reg <= ST_DELAY;
            end else begin
              state_reg <= ST_FAULT;
            end
          end
        end
        ST_DELAY: begin
          if (manual_clear && correctable) begin
            state_reg <= ST_RUN;
          end else if (delay_reg == 8'h00) begin
            state_reg <= ST_TRY;
          end else if (tick_reg == TICK_W'(TICK_CYCLES - 1)) begin
            tick_reg  <= '0;
            delay_reg <= delay_reg - 8'h01;
          end else begin
            tick_reg <= tick_reg + TICK_W'(1);
          end
        end
        ST_TRY: begin
          tries_reg <= tries_reg + 4'h1;
          if (!cause_present) begin
            state_reg <= ST_RUN;
            // Zero delay on supply/thermal faults clears without a start
            auto_start_reg <= !(restart_delay_setting == 8'h00 && quiet_fault);
          end else if (tries_reg + 4'h1 < restart_attempt_limit) begin
            delay_reg <= restart_delay_setting;
            tick_reg  <= '0;
            state_reg <= ST_DELAY;
          end else begin
            state_reg <= ST_FAULT;
          end
        end
        ST_FAULT: begin
          if (manual_clear && correctable) begin
            state_reg <= ST_RUN;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // Sequencer checks
  AST_CLASS2_NO_AUTO: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_RUN && fault_detect && fault_class2)
    |=> state_reg == ST_FAULT)
    else $error("class 2 fault entered auto restart");
  AST_CLASS_KEPT: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_RUN && fault_detect)
    |=> class2_reg == $past(fault_class2))
    else $error("fault class not latched");
  AST_DELAY_START: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_RUN && fault_detect && !fault_class2 && restart_attempt_limit != 4'h0)
    |=> state_reg == ST_DELAY && delay_reg == $past(restart_delay_setting))
    else $error("restart delay not loaded");
  AST_NO_LIMIT: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_RUN && fault_detect && restart_attempt_limit == 4'h0)
    |=> state_reg == ST_FAULT)
    else $error("auto restart without attempt limit");
  AST_DELAY_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_DELAY && delay_reg != 8'h00 && !manual_clear)
    |=> state_reg == ST_DELAY)
    else $error("restart delay cut short");
  AST_ZERO_TRIES: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_DELAY && delay_reg == 8'h00 && !manual_clear)
    |=> state_reg == ST_TRY)
    else $error("no attempt at delay end");
  AST_TRY_ONCE: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_TRY
    |=> state_reg != ST_TRY)
    else $error("attempt held longer than one cycle");
  AST_TRY_OUTCOME: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_TRY && cause_present)
    |=> state_reg != ST_RUN)
    else $error("fault reset with cause present");
  AST_TRY_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_TRY && !cause_present)
    |=> state_reg == ST_RUN)
    else $error("attempt left fault latched");
  AST_START_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    auto_start_reg
    |=> !auto_start_reg)
    else $error("start command longer than one cycle");
  AST_NO_CLEAR_ACTIVE: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_FAULT && cause_present)
    |=> state_reg == ST_FAULT)
    else $error("fault cleared while cause active");
  AST_FAULT_STAYS: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_FAULT && !(manual_clear && correctable))
    |=> state_reg == ST_FAULT)
    else $error("latched fault left without a clear");
  AST_STOP_GATED: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_FAULT && stop_key && stop_behaviour_select > STOP_CLEAR_MAX
     && !fault_clear_write && input_terminal_function != TERM_FN_CLEAR)
    |=> state_reg == ST_FAULT) else $error("stop key cleared fault");
  AST_STOP_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_FAULT && !cause_present && stop_key
     && stop_behaviour_select <= STOP_CLEAR_MAX) |=> state_reg == ST_RUN)
    else $error("stop key clear ignored");
  AST_CMD_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_FAULT && !cause_present && fault_clear_write
     && fault_clear_command == CLEAR_CMD_B) |=> state_reg == ST_RUN)
    else $error("clear command ignored");
  AST_CMD_OTHER: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_FAULT && fault_clear_write && fault_clear_command != CLEAR_CMD_A
     && fault_clear_command != CLEAR_CMD_B && !stop_key
     && input_terminal_function != TERM_FN_CLEAR) |=> state_reg == ST_FAULT)
    else $error("other clear command value cleared fault");
  AST_TERM_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_FAULT && !cause_present && input_terminal_function == TERM_FN_CLEAR
     && input_terminal_level != term_prev_reg) |=> state_reg == ST_RUN)
    else $error("terminal toggle clear ignored");
  AST_QUIET_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_TRY && !cause_present && quiet_fault
     && restart_delay_setting == 8'h00) |=> !auto_start_reg)
    else $error("restart after quiet clear");
  AST_TRIES_RESET: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_RUN && fault_detect)
    |=> tries_reg == 4'h0)
    else $error("attempt count not cleared for new episode");
  AST_TRY_LIMIT: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_TRY
    |-> tries_reg < restart_attempt_limit)
    else $error("attempts exceed limit");
  AST_LIMIT_STOP: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_TRY && cause_present && tries_reg + 4'h1 >= restart_attempt_limit)
    |=> state_reg == ST_FAULT)
    else $error("attempts went on past limit");

  // Motor held off whenever a fault is seen or latched
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      motor_enable_reg  <= 1'b0;
      fault_latched_reg <= 1'b0;
    end else begin
      fault_latched_reg <= (state_reg != ST_RUN) || fault_detect;
      motor_enable_reg  <= (state_reg == ST_RUN) && !fault_detect;
    end
  end

  AST_FAULT_STOPS: assert property (@(posedge clk) disable iff (!rst_b)
    fault_detect
    |=> !motor_enable_reg)
    else $error("motor not stopped on fault");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg != ST_RUN
    |=> !motor_enable_reg && fault_latched_reg)
    else $error("motor enabled while fault latched");
  AST_RESET_CLEARS: assert property (@(posedge clk)
    !rst_b
    |=> state_reg == ST_RUN && !fault_latched_reg && !motor_enable_reg)
    else $error("power cycle left fault latched");

  // Escape acknowledge and latest code record
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      keypad_owned_reg      <= 1'b1;
      latest_fault_code_reg <= FAULT_NONE;
    end else if (state_reg == ST_RUN && fault_detect) begin
      keypad_owned_reg <= 1'b0;
    end else if (state_reg != ST_RUN && escape_key) begin
      keypad_owned_reg      <= 1'b1;
      latest_fault_code_reg <= code_reg;
    end else if (state_reg == ST_RUN) begin
      keypad_owned_reg <= 1'b1;
    end
  end

  AST_ESC_RECORD: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_FAULT && escape_key)
    |=> keypad_owned_reg && fault_latched_reg
    && latest_fault_code_reg == $past(code_reg))
    else $error("escape acknowledge wrong");
  AST_ESC_KEEPS: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_FAULT && escape_key && !manual_clear)
    |=> state_reg == ST_FAULT)
    else $error("escape cleared the fault");

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash_cnt_reg <= '0;
      flash_reg     <= 1'b0;
    end else if (flash_cnt_reg == FLASH_W'(FLASH_CYCLES - 1)) begin
      flash_cnt_reg <= '0;
      flash_reg     <= !flash_reg;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + FLASH_W'(1);
    end
  end

  // Flashing decimal code, e.g. 004
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      display_reg <= '0;
    end else begin
      display_reg.hundreds      <= 4'(code_reg / 8'd100);
      display_reg.tens          <= 4'((code_reg % 8'd100) / 8'd10);
      display_reg.units         <= 4'(code_reg % 8'd10);
      display_reg.message_shown <= (state_reg != ST_RUN) && !keypad_owned_reg;
      display_reg.digits_on     <= (state_reg != ST_RUN) && !keypad_owned_reg && flash_reg;
      display_reg.indicator_on  <= (state_reg != ST_RUN) && flash_reg;
    end
  end

  AST_IDLE_DARK: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_RUN
    |=> !display_reg.indicator_on && !display_reg.message_shown)
    else $error("fault display shown with no fault");
  AST_DIGITS_HIDDEN: assert property (@(posedge clk) disable iff (!rst_b)
    keypad_owned_reg
    |=> !display_reg.digits_on && !display_reg.message_shown)
    else $error("fault message kept after acknowledge");
endmodule : drive_fault_restart_manager
`default_nettype wire

// *** logic/fault_mgr_pkg.sv ***
/*
  Constants and carrier types for the drive fault restart manager.
  Assumes a 100 MHz system clock and fault detectors outside this block.
*/
package fault_mgr_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned DELAY_UNIT_MS   = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * DELAY_UNIT_MS;
  localparam int unsigned TICK_W          = 17;
  localparam logic [7:0]  FAULT_NONE      = 8'h00;
  localparam logic [7:0]  FAULT_UNDERVOLT = 8'h04;
  localparam logic [7:0]  FAULT_OVERVOLT  = 8'h05;
  localparam logic [7:0]  FAULT_HEATSINK  = 8'h08;
  localparam logic [1:0]  CLEAR_CMD_A     = 2'h1;
  localparam logic [1:0]  CLEAR_CMD_B     = 2'h2;
  localparam logic [3:0]  STOP_CLEAR_MAX  = 4'h3;
  localparam logic [4:0]  TERM_FN_CLEAR   = 5'h0a;
  localparam int unsigned FLASH_CYCLES    = 50_000_000;
  localparam int unsigned FLASH_W         = 26;

  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_FAULT = 4'b0010,
    ST_DELAY = 4'b0100,
    ST_TRY   = 4'b1000
  } fault_state_t;

  typedef struct packed {
    logic [3:0] hundreds;
    logic [3:0] tens;
    logic [3:0] units;
    logic       digits_on;
    logic       indicator_on;
    logic       message_shown;
  } display_t;
endpackage : fault_mgr_pkg

// *** sim/fault_source_model.sv ***
/*
  Fault detector model: raises and drops a fault condition on command.
  Assumes commands are changed off the rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_source_model (
  input  wire logic       clk,
  input  wire logic       raise,
  input  wire logic       drop,
  input  wire logic [7:0] code_in,
  input  wire logic       class2_in,
  output var  logic       fault_detect = 1'b0,
  output var  logic [7:0] fault_code = 8'h00,
  output var  logic       fault_class2 = 1'b0
);
  always @(posedge clk) begin
    if (raise) begin
      fault_detect <= 1'b1;
      fault_code   <= code_in;
      fault_class2 <= class2_in;
    end else if (drop || !fault_detect) begin
      // Released lines do not keep the old value
      fault_detect <= 1'b0;
      fault_code   <= ~fault_code;
      fault_class2 <= ~fault_class2;
    end
  end
endmodule : fault_source_model
`default_nettype wire

// *** sim/tb_drive_fault_restart_manager.sv ***
/*
  Self-checking bench for the fault restart manager.
  Assumes the fault source model and the package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_drive_fault_restart_manager
  import fault_mgr_pkg::*;
;
  logic clk = 0, rst_b = 0, raise = 0, drop = 0, c2 = 0, det, fc2, clr_wr = 0, stop_key = 0;
  logic esc = 0, lvl = 0, mot, ast, lat, kp;
  logic [7:0] code = 0, fcode, last, dly = 0, v;
  logic [1:0] cmd = 0;
  logic [3:0] lim = 0, sel = 4'h4;
  logic [4:0] fn = 0;
  display_t disp;
  int miscompares = 0, check_count = 0, starts = 0, cycles = 0, n0;
  logic [7:0] v8 [4] = '{8'h06, FAULT_UNDERVOLT, FAULT_OVERVOLT, FAULT_HEATSINK};
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (ast === 1'b1) starts++;
    if (cycles == 4000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  fault_source_model src (.clk(clk), .raise(raise), .drop(drop), .code_in(code),
    .class2_in(c2), .fault_detect(det), .fault_code(fcode), .fault_class2(fc2));
  drive_fault_restart_manager dut (.clk(clk), .rst_b(rst_b), .fault_detect(det),
    .fault_code(fcode), .fault_class2(fc2), .restart_attempt_limit(lim),
    .restart_delay_setting(dly), .fault_clear_write(clr_wr), .fault_clear_command(cmd),
    .stop_behaviour_select(sel), .stop_key(stop_key), .escape_key(esc),
    .input_terminal_function(fn), .input_terminal_level(lvl), .motor_enable_reg(mot),
    .auto_start_reg(ast), .fault_latched_reg(lat), .keypad_owned_reg(kp),
    .latest_fault_code_reg(last), .display_reg(disp));
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: value got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic fault(input logic [7:0] c, input logic cls, input logic keep);
    code = c;
    c2 = cls;
    raise = 1;
    cyc(1);
    raise = 0;
    drop = !keep;
    cyc(1);
    drop = 0;
    cyc(3);
  endtask : fault
  task automatic write_clear(input logic [1:0] c);
    cmd = c;
    clr_wr = 1;
    cyc(1);
    clr_wr = 0;
    cyc(3);
  endtask : write_clear
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(32'hb9ef));
    cyc(4);
    chk1(lat, 0);
    chk1(kp, 1);
    chk8(last, 8'h00);
    rst_b = 1;
    cyc(3);
    chk1(mot, 1);
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom % 255 + 1);
      lim = 4'($urandom % 15 + 1);
      fault(v, 1, 1);
      chk1(mot, 0);
      chk1(disp.message_shown, 1);
      chk8({4'h0, disp.hundreds}, v / 100);
      chk8({disp.tens, disp.units}, {4'(v / 10 % 10), 4'(v % 10)});
      chk1(disp.indicator_on, 1'((cycles / FLASH_CYCLES) % 2));
      chk1(disp.digits_on, 1'((cycles / FLASH_CYCLES) % 2));
      write_clear(2'($urandom % 2 + 1));
      chk1(lat, 1);
      drop = 1;
      cyc(1);
      drop = 0;
      cyc(10);
      chk1(lat, 1);
      chk1(mot, 0);
      write_clear({2{1'($urandom)}});
      chk1(lat, 1);
      esc = 1;
      cyc(1);
      esc = 0;
      cyc(2);
      chk1(kp, 1);
      chk8(last, v);
      chk1(disp.message_shown, 0);
      chk1(lat, 1);
      write_clear(CLEAR_CMD_A);
      chk1(lat, 0);
      chk1(mot, 1);
    end
    $display("class 2 test done");
    lim = 0;
    fault(8'h07, 0, 0);
    stop_key = 1;
    cyc(1);
    stop_key = 0;
    cyc(3);
    chk1(lat, 1);
    sel = 4'($urandom % 4);
    stop_key = 1;
    cyc(1);
    stop_key = 0;
    cyc(3);
    chk1(lat, 0);
    fault(8'h0c, 0, 0);
    fn = TERM_FN_CLEAR;
    lvl = 1;
    cyc(3);
    chk1(lat, 0);
    fn = 0;
    $display("manual clear test done");
    lim = 1;
    foreach (v8[k]) begin
      n0 = starts;
      fault(v8[k], 0, 0);
      cyc(2);
      chk1(lat, 0);
      chk1(mot, 1);
      chk8(8'(starts - n0), {7'h0, k == 0});
    end
    lim = 2;
    n0 = starts;
    fault(8'h06, 0, 1);
    cyc(20);
    chk1(lat, 1);
    drop = 1;
    cyc(1);
    drop = 0;
    cyc(10);
    chk1(lat, 1);
    chk8(8'(starts - n0), 8'h00);
    write_clear(CLEAR_CMD_B);
    chk1(lat, 0);
    $display("auto restart test done");
    fault(8'h0d, 1, 1);
    chk1(lat, 1);
    rst_b = 0;
    drop = 1;
    cyc(1);
    drop = 0;
    cyc(1);
    chk1(lat, 0);
    chk1(mot, 0);
    chk1(kp, 1);
    rst_b = 1;
    cyc(3);
    chk1(mot, 1);
    chk1(lat, 0);
    $display("power cycle test done");
    tally_and_finish();
  end
endmodule : tb_drive_fault_restart_manager
`default_nettype wire
